// ---- core/secmon_defines.svh ----
// offsets, field positions, reset values and timing counts of the monitor
`ifndef SECMON_DEFINES_SVH
`define SECMON_DEFINES_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SECMON_OFS_STATUS   8'h00
`define SECMON_OFS_CLEAR    8'h04
`define SECMON_OFS_IRQ_EN   8'h08
`define SECMON_OFS_REACT    8'h0c
`define SECMON_OFS_OPSEL    8'h10
`define SECMON_OFS_LIFE     8'h14
`define SECMON_OFS_TRACE    8'h18
`define SECMON_OFS_SECATTR  8'h1c
`define SECMON_OFS_GUARD    8'h40
// guard bank: 2 memories x 4 partitions x 3 words, 4 bytes each
`define SECMON_GUARD_WORDS  24
// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define SECMON_NUM_DET      4
`define SECMON_BIT_FILTER   4
`define SECMON_BIT_INTEG    5
`define SECMON_BIT_LIFE     6
`define SECMON_BIT_UNMAP    7
`define SECMON_BIT_PROHIB   8
`define SECMON_BIT_SECREF   9
`define SECMON_BIT_TESTREJ  10
`define SECMON_NUM_EV       11
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SECMON_RST_REACT    11'h000
`define SECMON_RST_GUARD    32'h0000_0000
`define SECMON_RST_SECATTR  2'h0
// ----------------------------------------------------------------------
// timing: glitch filter length in ns and cycles at 100 MHz
// ----------------------------------------------------------------------
`define SECMON_FILT_NS      40
`define SECMON_CLK_NS       10
`define SECMON_FILT_CYC     ((`SECMON_FILT_NS + `SECMON_CLK_NS - 1) / `SECMON_CLK_NS)
`endif

// ---- core/secmon_pkg.sv ----
// types shared by the security monitor
package secmon_pkg;
  // lifecycle states, gray along load -> test -> normal
  typedef enum logic [1:0] {
    SECMON_LC_LOAD   = 2'b00,
    SECMON_LC_TEST   = 2'b01,
    SECMON_LC_NORMAL = 2'b11
  } secmon_lc_t;
  // non-volatile image presented at reset
  typedef struct packed {
    logic normal;     // lifecycle already advanced
    logic flash_boot; // boot-source choice
    logic boot_lock;  // boot choice locked
  } secmon_nvm_t;
  // test-port command group
  typedef struct packed {
    logic        valid;
    logic [1:0]  cmd;
    logic [31:0] data;
  } secmon_tcmd_t;
  // processor access to check against partitions
  typedef struct packed {
    logic        valid;
    logic        user;
    logic        write;
    logic        flash;
    logic [31:0] addr;
  } secmon_acc_t;
endpackage : secmon_pkg

// ---- core/secmon_top.sv ----
// security monitor: detector reactions, filters, partitions, lifecycle
// Function
// - reset reaction resets chip immediately
// - flag reaction sets a status bit
// - software selects reaction, never disables detection
// - all registers take defaults on reset
// - unmapped bus addresses are detected and reported
// - prohibited partition access is trapped
// - security registers obey access attributes
// - base, limit, attribute per partition, flash/RAM
// - boot from boot memory or flash
// - normal never returns to test
// - test entry needs correct password
// - test commands rejected in normal mode
// - functional tests only in test mode
// - traceability read-only after normal
// - reset and clock pads are glitch filtered
// - lifetime monitor flags tampered detector lines
`timescale 1ns/1ps
`include "secmon_defines.svh"
module secmon_top #(
  parameter logic [31:0] TEST_PASSWORD = 32'h5a5a_a5a5 // arbitrary value
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic [1:0]                 avs_response,
  input  wire logic                  cpu_privileged,
  // detector lines and their lifetime reference copies
  input  wire logic [3:0]            det_evt,
  input  wire logic [3:0]            det_ref_n,
  input  wire logic                  integ_evt,
  // raw pads
  input  wire logic                  pad_reset_n,
  input  wire logic                  pad_clk,
  output logic                       filt_reset_n,
  output logic                       filt_clk,
  // nvm image and write-back strobe
  input  wire secmon_pkg::secmon_nvm_t nvm_image,
  output secmon_pkg::secmon_nvm_t    nvm_wdata,
  output logic                       nvm_we,
  // processor access check
  input  wire secmon_pkg::secmon_acc_t cpu_acc,
  output logic                       cpu_trap,
  // test port
  input  wire secmon_pkg::secmon_tcmd_t test_cmd,
  output logic                       test_ack,
  output logic                       test_nak,
  output logic                       functest_en,
  // system outputs
  output logic                       chip_reset_req,
  output logic                       cpu_start,
  output logic                       boot_from_flash,
  output logic                       irq
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  localparam int NEV = `SECMON_NUM_EV;
  secmon_pkg::secmon_lc_t lc_q;         // lifecycle state
  logic [NEV-1:0]         status_q;     // sticky event flags
  logic [NEV-1:0]         irq_en_q;     // interrupt enables
  logic [NEV-1:0]         react_q;      // 1 = reset reaction
  logic                   flash_boot_q; // boot source
  logic                   boot_lock_q;  // boot source locked
  logic [31:0]            trace_q;      // traceability word
  logic [1:0]             secattr_q;    // bit0 user may access, bit1 lock
  logic [31:0]            guard_q [`SECMON_GUARD_WORDS]; // partitions
  logic [NEV-1:0]         ev;           // raw event vector
  logic                   acc;          // bus request present
  logic                   wr_hit, rd_ok, mapped, refused;
  logic [4:0]             gidx;         // guard word index
  logic                   is_guard;
  // --------------------------------------------------------------------
  // bus decode: writes finish at once; a read holds one wait state so
  // that the registered read data stand at the edge that ends it
  // --------------------------------------------------------------------
  logic rd_wait_q; // first read cycle seen, read data now loaded
  assign avs_waitrequest = avs_read && !rd_wait_q;
  // wait-state tracker, drops at the edge that completes the read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= avs_read && !rd_wait_q;
    end
  end
  assign acc      = avs_read | avs_write;
  assign is_guard = (avs_address >= `SECMON_OFS_GUARD) &&
                    (avs_address < 8'(`SECMON_OFS_GUARD +
                                      4 * `SECMON_GUARD_WORDS));
  assign gidx     = 5'((avs_address - `SECMON_OFS_GUARD) >> 2);
  always_comb begin
    mapped = 1'b0;
    if (avs_address[1:0] == 2'h0) begin
      case (avs_address)
        `SECMON_OFS_STATUS, `SECMON_OFS_CLEAR, `SECMON_OFS_IRQ_EN,
        `SECMON_OFS_REACT, `SECMON_OFS_OPSEL, `SECMON_OFS_LIFE,
        `SECMON_OFS_TRACE, `SECMON_OFS_SECATTR: mapped = 1'b1;
        default: mapped = is_guard;
      endcase
    end
  end
  // user-mode access to security registers needs the attribute bit
  assign refused = acc && mapped && !cpu_privileged && !secattr_q[0];
  assign wr_hit  = avs_write && mapped && !refused;
  assign rd_ok   = avs_read && mapped && !refused;
  // --------------------------------------------------------------------
  // event sources
  // --------------------------------------------------------------------
  logic [1:0] filt_glitch; // filter rejected a pad pulse
  always_comb begin
    ev = '0;
    ev[`SECMON_NUM_DET-1:0] = det_evt;
    ev[`SECMON_BIT_FILTER]  = |filt_glitch;
    ev[`SECMON_BIT_INTEG]   = integ_evt;
    // detector line must always be the inverse of its reference copy
    ev[`SECMON_BIT_LIFE]    = |(det_evt ~^ det_ref_n);
    ev[`SECMON_BIT_UNMAP]   = acc && !mapped;
    ev[`SECMON_BIT_PROHIB]  = cpu_trap;
    ev[`SECMON_BIT_SECREF]  = refused;
    ev[`SECMON_BIT_TESTREJ] = test_nak;
  end
  // --------------------------------------------------------------------
  // sticky status: set wins over software clear
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      // events feed in regardless of any setting
      status_q <= (status_q &
        ~((wr_hit && avs_address == `SECMON_OFS_CLEAR) ?
          avs_writedata[NEV-1:0] : '0)) | ev;
    end
  end
  assign irq = |(status_q & irq_en_q);
  // reset reaction is combinational so it acts in the event cycle
  assign chip_reset_req = |(ev & react_q);
  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_q  <= '0;
      react_q   <= `SECMON_RST_REACT;
      secattr_q <= `SECMON_RST_SECATTR;
    end else if (wr_hit) begin
      case (avs_address)
        `SECMON_OFS_IRQ_EN: irq_en_q <= avs_writedata[NEV-1:0];
        `SECMON_OFS_REACT:  react_q  <= avs_writedata[NEV-1:0];
        `SECMON_OFS_SECATTR: begin
          // once locked, attributes stay until reset
          if (!secattr_q[1] && cpu_privileged) begin
            secattr_q <= avs_writedata[1:0];
          end
        end
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // partition guard registers, generated per word
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SECMON_GUARD_WORDS; gi++) begin : g_guard
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          guard_q[gi] <= `SECMON_RST_GUARD;
        end else if (wr_hit && is_guard && gidx == 5'(gi)) begin
          guard_q[gi] <= avs_writedata;
        end
      end
    end
  endgenerate
  // word 3*p+0 base, +1 limit, +2 attr; flash p=0..3, ram p=4..7
  // attr bit0 enable, bit1 user read, bit2 user write
  always_comb begin
    logic [2:0] bank;
    logic       hit_ok;
    bank   = 3'h0;
    hit_ok = 1'b0;
    // any enabled partition of the accessed memory (flash or ram) that grants the access clears the trap
    for (int p = 0; p < 4; p++) begin
      bank = 3'(cpu_acc.flash ? p : p + 4);
      if (guard_q[3*bank+2][0] &&
          cpu_acc.addr >= guard_q[3*bank] &&
          cpu_acc.addr <= guard_q[3*bank+1] &&
          (cpu_acc.write ? guard_q[3*bank+2][2] : guard_q[3*bank+2][1]))
        hit_ok = 1'b1;
    end
    // privileged code passes; user code needs a granting partition
    cpu_trap = cpu_acc.valid && cpu_acc.user && !hit_ok;
  end
  // --------------------------------------------------------------------
  // lifecycle, boot selection and nvm reload
  // --------------------------------------------------------------------
  logic auth_q;   // password accepted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lc_q         <= secmon_pkg::SECMON_LC_LOAD;
      flash_boot_q <= 1'b0;
      boot_lock_q  <= 1'b0;
      auth_q       <= 1'b0;
    end else begin
      case (lc_q)
        secmon_pkg::SECMON_LC_LOAD: begin
          // image taken one edge after release, before cpu start
          flash_boot_q <= nvm_image.flash_boot;
          boot_lock_q  <= nvm_image.boot_lock;
          lc_q <= nvm_image.normal ? secmon_pkg::SECMON_LC_NORMAL
                                   : secmon_pkg::SECMON_LC_TEST;
        end
        secmon_pkg::SECMON_LC_TEST: begin
          if (test_cmd.valid && test_cmd.cmd == 2'h0)
            auth_q <= (test_cmd.data == TEST_PASSWORD);
          if (test_cmd.valid && test_cmd.cmd == 2'h3 && auth_q)
            lc_q <= secmon_pkg::SECMON_LC_NORMAL;
        end
        secmon_pkg::SECMON_LC_NORMAL: begin
          auth_q <= 1'b0;
          lc_q   <= secmon_pkg::SECMON_LC_NORMAL;
        end
        default: lc_q <= secmon_pkg::SECMON_LC_LOAD;
      endcase
      if (wr_hit && avs_address == `SECMON_OFS_OPSEL &&
          lc_q != secmon_pkg::SECMON_LC_LOAD && !boot_lock_q) begin
        flash_boot_q <= avs_writedata[0];
        boot_lock_q  <= avs_writedata[1];
      end
    end
  end
  assign cpu_start       = lc_q != secmon_pkg::SECMON_LC_LOAD;
  assign boot_from_flash = flash_boot_q;
  // test port answer: ack when accepted, nak when refused
  // the password is compared in the cycle it is presented
  always_comb begin
    test_ack = 1'b0;
    test_nak = 1'b0;
    if (test_cmd.valid) begin
      if (lc_q != secmon_pkg::SECMON_LC_TEST) begin
        test_nak = 1'b1;
      end else if (test_cmd.cmd == 2'h0) begin
        test_ack = test_cmd.data == TEST_PASSWORD;
        test_nak = !test_ack;
      end else begin
        test_ack = auth_q;
        test_nak = !auth_q;
      end
    end
  end
  assign functest_en = (lc_q == secmon_pkg::SECMON_LC_TEST) && auth_q;
  // nvm write-back on the normal switch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvm_we    <= 1'b0;
      nvm_wdata <= '0;
    end else begin
      nvm_we    <= (lc_q == secmon_pkg::SECMON_LC_TEST) && test_cmd.valid &&
                   test_cmd.cmd == 2'h3 && auth_q;
      nvm_wdata <= '{normal: 1'b1, flash_boot: flash_boot_q,
                     boot_lock: boot_lock_q};
    end
  end
  // traceability: written through test port only while in test mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trace_q <= '0;
    end else if (lc_q == secmon_pkg::SECMON_LC_TEST && auth_q &&
                 test_cmd.valid && test_cmd.cmd == 2'h1) begin
      trace_q <= test_cmd.data;
    end
  end
  // --------------------------------------------------------------------
  // pad glitch filters, one per pad
  // --------------------------------------------------------------------
  // a pad must differ for FN edges in a row before its output follows
  localparam int FN = `SECMON_FILT_CYC;
  logic [1:0] pad_in;
  logic [1:0] filt_q;
  assign pad_in = {pad_clk, pad_reset_n};
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [3:0] cnt_q; // cycles the pad differed from output
      logic       out_q; // filtered level of this pad
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_q <= '0;
          out_q <= (gi == 0);
        end else if (pad_in[gi] == out_q) begin
          cnt_q <= '0;
        end else if (cnt_q == 4'(FN - 1)) begin
          cnt_q <= '0;
          out_q <= pad_in[gi];
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
      assign filt_q[gi] = out_q;
      // pulse shorter than the filter length is reported
      assign filt_glitch[gi] = (cnt_q != 4'h0) && (pad_in[gi] == out_q);
    end
  endgenerate
  assign filt_reset_n = filt_q[0];
  assign filt_clk     = filt_q[1];
  // --------------------------------------------------------------------
  // read data and response register
  // loaded in both read cycles; the master takes the first copy
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else begin
      avs_readdata <= '0;
      avs_response <= (acc && (!mapped || refused)) ? 2'h2 : 2'h0;
      if (rd_ok) begin
        case (avs_address)
          `SECMON_OFS_STATUS:  avs_readdata <= 32'(status_q);
          `SECMON_OFS_IRQ_EN:  avs_readdata <= 32'(irq_en_q);
          `SECMON_OFS_REACT:   avs_readdata <= 32'(react_q);
          `SECMON_OFS_OPSEL:   avs_readdata <= {30'h0, boot_lock_q,
                                                flash_boot_q};
          `SECMON_OFS_LIFE:    avs_readdata <= {30'h0, lc_q};
          `SECMON_OFS_TRACE:   avs_readdata <= trace_q;
          `SECMON_OFS_SECATTR: avs_readdata <= {30'h0, secattr_q};
          default: if (is_guard) avs_readdata <= guard_q[gidx];
        endcase
      end
    end
  end
endmodule : secmon_top

// ---- testbench/secmon_top_sva.sv ----
// port assertions for the security monitor
`timescale 1ns/1ps
module secmon_sva #(
  parameter logic [31:0] TEST_PASSWORD = 32'h5a5a_a5a5 // arbitrary value
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic [7:0]               avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [1:0]               avs_response,
  input wire logic                     pad_reset_n,
  input wire logic                     filt_reset_n,
  input wire logic                     nvm_we,
  input wire secmon_pkg::secmon_nvm_t  nvm_wdata,
  input wire secmon_pkg::secmon_tcmd_t test_cmd,
  input wire logic                     test_ack,
  input wire logic                     test_nak,
  input wire logic                     functest_en,
  input wire logic                     cpu_start
);
  // ------------------------------------------------------------
  // helper terms and properties
  // ------------------------------------------------------------
  logic unmap;  // address hits no register
  logic pwd_ok; // correct password accepted
  assign unmap = (avs_address >= 8'h20 && avs_address < 8'h40) ||
                 avs_address > 8'h9c;
  assign pwd_ok = test_cmd.valid && test_cmd.cmd == 2'h0 && test_ack &&
                  test_cmd.data == TEST_PASSWORD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_unmap_refused: assert property (
    (avs_read || avs_write) && unmap |=> avs_response == 2'h2)
    else $error("unmapped access not refused");
  a_bad_pwd: assert property (
    test_cmd.valid && test_cmd.cmd == 2'h0 &&
    test_cmd.data != TEST_PASSWORD |-> !test_ack)
    else $error("wrong password accepted");
  a_one_answer: assert property (
    test_ack || test_nak |-> test_cmd.valid && test_ack != test_nak)
    else $error("test port answer malformed");
  a_func_entry: assert property (
    $rose(functest_en) |-> $past(pwd_ok))
    else $error("functional test opened without password");
  a_switch_write: assert property (
    test_cmd.valid && test_cmd.cmd == 2'h3 && test_ack |-> ##[1:2] nvm_we)
    else $error("switch to normal not written back");
  a_nvm_pulse: assert property (
    nvm_we |-> nvm_wdata.normal ##1 !nvm_we)
    else $error("write-back not a single normal pulse");
  a_filt_hold: assert property (
    $changed(filt_reset_n) |-> $past(pad_reset_n, 2) == filt_reset_n &&
    $past(pad_reset_n, 3) == filt_reset_n)
    else $error("reset filter passed a short pulse");
  a_start_held: assert property (
    $past(rst_n) |-> cpu_start)
    else $error("processor start dropped");
endmodule : secmon_sva
bind secmon_top secmon_sva #(.TEST_PASSWORD(TEST_PASSWORD)) secmon_sva_inst (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_response(avs_response),
  .pad_reset_n(pad_reset_n), .filt_reset_n(filt_reset_n), .nvm_we(nvm_we),
  .nvm_wdata(nvm_wdata), .test_cmd(test_cmd), .test_ack(test_ack),
  .test_nak(test_nak), .functest_en(functest_en), .cpu_start(cpu_start));

// ---- testbench/secmon_top_bench.sv ----
// self-checking bench of the security monitor
`timescale 1ns/1ps
`include "secmon_defines.svh"
module secmon_top_bench;
  localparam logic [31:0] PWD = 32'h3c3c_0f0f; // arbitrary value
  logic                     clk = 1'b0; // 100 mhz clock
  logic                     rst_n, avs_rd, avs_wr, priv, pad_rn, integ;
  logic                     wait_s, trap, ack, nak, fte, creq, bff, irq;
  logic                     start, frst, nwe, pclk, fclk;
  logic [7:0]               addr;
  logic [31:0]              wdata, rdata, seed, tr, rval;
  logic [31:0]              g [24]; // random partition contents
  logic [3:0]               det, ref_n;
  logic [1:0]               resp, rrsp;
  secmon_pkg::secmon_nvm_t  nvm_in, nvm_out;
  secmon_pkg::secmon_acc_t  acc;
  secmon_pkg::secmon_tcmd_t tcmd;
  int                       bad_count, n_compared, n_we;
  secmon_top #(.TEST_PASSWORD(PWD)) secmon_top_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(avs_rd),
    .avs_write(avs_wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wait_s), .avs_response(resp),
    .cpu_privileged(priv), .det_evt(det), .det_ref_n(ref_n),
    .integ_evt(integ), .pad_reset_n(pad_rn), .pad_clk(pclk),
    .filt_reset_n(frst), .filt_clk(fclk), .nvm_image(nvm_in),
    .nvm_wdata(nvm_out), .nvm_we(nwe), .cpu_acc(acc), .cpu_trap(trap),
    .test_cmd(tcmd), .test_ack(ack), .test_nak(nak), .functest_en(fte),
    .chip_reset_req(creq), .cpu_start(start), .boot_from_flash(bff),
    .irq(irq));
  always #5 clk = ~clk; // half period
  // counts normal write-back pulses
  always @(posedge clk) if (nwe === 1'b1 && nvm_out === 3'b111) n_we++;
  function automatic logic [31:0] rnd(); // xorshift source
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ev(int i); // one status bit
    return 32'h1 << i;
  endfunction : ev
  function automatic logic [7:0] gofs(int i); // partition word offset
    return `SECMON_OFS_GUARD + 8'(4 * i);
  endfunction : gofs
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    {addr, wdata, avs_rd, avs_wr} <= {a, d, !w, w};
    do @(posedge clk); while (wait_s !== 1'b0);
    {rval, rrsp} = {rdata, resp}; // taken at the ending edge
    {avs_rd, avs_wr} <= 2'b00;
    @(posedge clk);
  endtask : bus
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
    bus(1'b0, a, 32'h0);
    check(rval, e);
    check(32'(rrsp), 32'(er));
  endtask : rd
  task automatic clr();
    bus(1'b1, `SECMON_OFS_CLEAR, 32'h7ff);
  endtask : clr
  task automatic tc(logic [1:0] c, logic [31:0] d, logic e);
    tcmd <= '{1'b1, c, d};
    #1 check(32'({ack, nak}), 32'({e, !e}));
    @(posedge clk);
    tcmd <= '0;
    repeat (2) @(posedge clk);
  endtask : tc
  task automatic fire(logic [3:0] d, logic [3:0] rn, logic ig, logic e);
    {det, ref_n, integ} <= {d, rn, ig};
    #1 check(32'(creq), 32'(e));
    @(posedge clk);
    {det, ref_n, integ} <= {4'h0, 4'hf, 1'b0};
    @(posedge clk);
  endtask : fire
  task automatic probe(logic u, logic w, logic f, logic [31:0] a, logic e);
    acc <= '{1'b1, u, w, f, a};
    #1 check(32'(trap), 32'(e));
    @(posedge clk);
    acc <= '0;
    @(posedge clk);
  endtask : probe
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  initial begin // watchdog
    #300000;
    bad_count++;
    summarize();
  end
  initial begin
    {rst_n, avs_rd, avs_wr, addr, wdata, det, integ, acc, tcmd, pclk} = '0;
    {priv, pad_rn, ref_n, seed} = {2'b11, 4'hf, 32'h5939};
    {nvm_in, bad_count, n_compared, n_we} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(start), 32'h1);
    rd(`SECMON_OFS_STATUS, 32'h0);
    rd(`SECMON_OFS_REACT, 32'h0);
    rd(`SECMON_OFS_SECATTR, 32'h0);
    rd(`SECMON_OFS_LIFE, 32'h1);
    for (int i = 0; i < `SECMON_GUARD_WORDS; i++) begin
      g[i] = (i % 3 == 2) ? rnd() & 32'h7 : rnd();
      rd(gofs(i), 32'h0);
      bus(1'b1, gofs(i), g[i]);
    end
    for (int i = 0; i < `SECMON_GUARD_WORDS; i++) begin
      rd(gofs(i), g[i]);
      bus(1'b1, gofs(i), 32'h0);
    end
    rd(8'h20, 32'h0, 2'h2);
    rd(8'ha0, 32'h0, 2'h2);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_UNMAP));
    clr();
    priv <= 1'b0;
    rd(`SECMON_OFS_REACT, 32'h0, 2'h2);
    priv <= 1'b1;
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_SECREF));
    clr();
    bus(1'b1, `SECMON_OFS_SECATTR, 32'h3);
    bus(1'b1, `SECMON_OFS_SECATTR, 32'h0);
    rd(`SECMON_OFS_SECATTR, 32'h3);
    bus(1'b1, `SECMON_OFS_IRQ_EN, 32'h7ff);
    priv <= 1'b0;
    for (int i = 0; i < `SECMON_NUM_DET; i++) begin
      fire(4'(ev(i)), ~4'(ev(i)), 1'b0, 1'b0);
      check(32'(irq), 32'h1);
      rd(`SECMON_OFS_STATUS, ev(i));
      clr();
      bus(1'b1, `SECMON_OFS_REACT, ev(i));
      fire(4'(ev(i)), ~4'(ev(i)), 1'b0, 1'b1);
      rd(`SECMON_OFS_STATUS, ev(i));
      clr();
    end
    priv <= 1'b1;
    fire(4'h0, 4'hf, 1'b1, 1'b0);
    bus(1'b1, `SECMON_OFS_IRQ_EN, 32'h0);
    check(32'(irq), 32'h0);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_INTEG));
    clr();
    fire(4'h0, 4'he, 1'b0, 1'b0);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_LIFE));
    rd(`SECMON_OFS_REACT, ev(3));
    clr();
    bus(1'b1, gofs(0), 32'h1000);
    bus(1'b1, gofs(1), 32'h1fff);
    bus(1'b1, gofs(2), 32'h1);
    probe(1'b1, 1'b0, 1'b1, 32'h1800, 1'b1);
    probe(1'b0, 1'b0, 1'b1, 32'h1800, 1'b0);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_PROHIB));
    bus(1'b1, gofs(2), 32'h3);
    probe(1'b1, 1'b0, 1'b1, 32'h1800, 1'b0);
    probe(1'b1, 1'b1, 1'b1, 32'h1800, 1'b1);
    probe(1'b1, 1'b0, 1'b0, 32'h1800, 1'b1);
    bus(1'b1, gofs(12), 32'h1000);
    bus(1'b1, gofs(13), 32'h1fff);
    bus(1'b1, gofs(14), 32'h7);
    probe(1'b1, 1'b1, 1'b0, 32'h1800, 1'b0);
    bus(1'b1, `SECMON_OFS_OPSEL, 32'h1);
    check(32'(bff), 32'h1);
    bus(1'b1, `SECMON_OFS_OPSEL, 32'h3);
    bus(1'b1, `SECMON_OFS_OPSEL, 32'h0);
    check(32'(bff), 32'h1);
    tc(2'h2, 32'h0, 1'b0);
    tc(2'h0, ~PWD, 1'b0);
    tc(2'h0, PWD, 1'b1);
    check(32'(fte), 32'h1);
    tc(2'h2, 32'h0, 1'b1);
    tr = rnd();
    tc(2'h1, tr, 1'b1);
    rd(`SECMON_OFS_TRACE, tr);
    clr();
    tc(2'h3, 32'h0, 1'b1);
    rd(`SECMON_OFS_LIFE, 32'h3);
    check(32'(n_we), 32'h1);
    tc(2'h0, PWD, 1'b0);
    tc(2'h1, ~tr, 1'b0);
    tc(2'h2, 32'h0, 1'b0);
    check(32'(fte), 32'h0);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_TESTREJ));
    bus(1'b1, `SECMON_OFS_TRACE, ~tr);
    rd(`SECMON_OFS_TRACE, tr);
    nvm_in <= '{1'b1, 1'b1, 1'b1};
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`SECMON_OFS_LIFE, 32'h3);
    check(32'(bff), 32'h1);
    tc(2'h0, PWD, 1'b0);
    pad_rn <= 1'b0;
    repeat (2) @(posedge clk);
    pad_rn <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(frst), 32'h1);
    pad_rn <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(frst), 32'h0);
    clr();
    pclk <= 1'b1;
    repeat (3) @(posedge clk);
    pclk <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(fclk), 32'h0);
    rd(`SECMON_OFS_STATUS, ev(`SECMON_BIT_FILTER));
    pclk <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(fclk), 32'h1);
    summarize();
  end
endmodule : secmon_top_bench
